// file: verilog/pmb_bank_defines.svh
`ifndef PMB_BANK_DEFINES_SVH
`define PMB_BANK_DEFINES_SVH
`define CMD_OT_WARN 8'h51
`define CMD_UT_WARN 8'h52
`define CMD_UT_FAULT 8'h53
`define CMD_UT_ACT 8'h54
`define CMD_OV_FAULT 8'h55
`define CMD_OV_ACT 8'h56
`define CMD_OV_WARN 8'h57
`define CMD_UV_WARN 8'h58
`define CMD_UV_FAULT 8'h59
`define CMD_UV_ACT 8'h5a
`define CMD_PG_ON 8'h5e
`define CMD_TON_DLY 8'h60
`define CMD_TURN_ON_RISE_TIME 8'h61
`define CMD_TOFF_DLY 8'h64
`define CMD_TURN_OFF_FALL_TIME 8'h65
`define CMD_ST_BYTE 8'h78
`define CMD_ST_WORD 8'h79
`define CMD_ST_VOUT 8'h7a
`define CMD_ST_IOUT 8'h7b
`define CMD_ST_INPUT 8'h7c
`define CMD_ST_TEMP 8'h7d
`define CMD_ST_CML 8'h7e
`define CMD_ST_MON 8'h80
`define CMD_RD_VIN 8'h88
`define CMD_RD_VOUT 8'h8b
`define CMD_RD_IOUT 8'h8c
`define CMD_RD_TEMP 8'h8d
`define I_OT_WARN 4'h0
`define I_UT_WARN 4'h1
`define I_UT_FAULT 4'h2
`define I_UT_ACT 4'h3
`define I_OV_FAULT 4'h4
`define I_OV_ACT 4'h5
`define I_OV_WARN 4'h6
`define I_UV_WARN 4'h7
`define I_UV_FAULT 4'h8
`define I_UV_ACT 4'h9
`define I_PG_ON 4'ha
`define I_TON_DLY 4'hb
`define I_TURN_ON_RISE_TIME 4'hc
`define I_TOFF_DLY 4'hd
`define I_TURN_OFF_FALL_TIME 4'he
`define NUM_RW 15
`define DEF_OT_WARN 16'heb48
`define DEF_UT_WARN 16'hdc40
`define DEF_UT_FAULT 16'he580
`define DEF_ACT 16'h0080
`define DEF_OV_FAULT 16'hd380
`define DEF_OV_WARN 16'hd353
`define UVW_MUL 22'sh00433
`define UVW_SHIFT 10
`define CML_CMD 7
`define CML_DATA 6
`define MS_NS 1000000
`define CLK_NS 50
`endif

// file: verilog/pmb_pkg.sv
package pmb_pkg;
  typedef enum logic [4:0] {
    BUS_IDLE = 5'b00001,
    BUS_RX = 5'b00010,
    BUS_ACK = 5'b00100,
    BUS_TX = 5'b01000,
    BUS_RACK = 5'b10000
  } pmb_bus_st_t;
  typedef enum logic [5:0] {
    SEQ_OFF = 6'b000001,
    SEQ_TON = 6'b000010,
    SEQ_RISE = 6'b000100,
    SEQ_ON = 6'b001000,
    SEQ_TOFF = 6'b010000,
    SEQ_FALL = 6'b100000
  } pmb_seq_st_t;
  typedef struct packed {
    logic [7:0] vout;
    logic [7:0] iout;
    logic [7:0] input_st;
    logic [7:0] temp;
    logic [7:0] mon;
  } pmb_fault_t;
  typedef struct packed {
    logic [15:0] vin;
    logic [15:0] vout;
    logic [15:0] iout;
    logic [15:0] temp;
  } pmb_tele_t;
  typedef struct packed {
    logic [15:0] uv_fault;
    logic [15:0] pg_on;
    logic [15:0] ton_dly;
    logic [15:0] turn_on_rise_time;
    logic [15:0] toff_dly;
    logic [15:0] turn_off_fall_time;
  } pmb_strap_t;
endpackage : pmb_pkg

// file: verilog/pmb_limit_bank.sv
`timescale 1ns/10ps
`include "pmb_bank_defines.svh"
module pmb_limit_bank
  import pmb_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h40,
  parameter int CYC_PER_MS = `MS_NS / `CLK_NS
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic enable_i,
  input wire logic clear_faults_i,
  input wire pmb_strap_t strap_i,
  input wire pmb_fault_t fault_i,
  input wire pmb_tele_t tele_i,
  output logic pgood_o,
  output logic ramp_up_o,
  output logic ramp_down_o,
  output logic out_on_o
);
  pmb_bus_st_t st_reg;
  pmb_seq_st_t sq_reg, sq_next;
  logic scl_q_reg, sda_q_reg;
  logic [3:0] bit_reg;
  logic [7:0] sh_reg, cmd_reg, wlo_reg, whi_reg;
  logic [2:0] bidx_reg;
  logic [1:0] rbyte_reg;
  logic rd_reg, oe_reg, mack_reg;
  logic [15:0] rdw_reg;
  logic [15:0] rw_reg [`NUM_RW];
  logic [15:0] dflt [`NUM_RW];
  pmb_fault_t fault_reg;
  logic [7:0] cml_reg;
  logic [15:0] tmr_reg;
  logic [31:0] pre_reg;
  logic pg_reg, up_reg, dn_reg, on_reg;
  // Bus events; pins are taken as already synchronous
  wire scl_rise = scl_i & ~scl_q_reg;
  wire scl_fall = ~scl_i & scl_q_reg;
  wire bus_start = scl_i & scl_q_reg & sda_q_reg & ~sda_i;
  wire bus_stop = scl_i & scl_q_reg & ~sda_q_reg & sda_i;
  wire byte_done = scl_fall && bit_reg == 4'h8;
  wire addr_ok = sh_reg[7:1] == DEV_ADDR;
  wire [2:0] bidx_inc = bidx_reg == 3'h4 ? bidx_reg : bidx_reg + 3'h1;
  wire [7:0] tx_byte = rbyte_reg == 2'h0 ? rdw_reg[7:0] :
                       rbyte_reg == 2'h1 ? rdw_reg[15:8] : 8'h00;
  // Command decode
  logic rw_hit, rw_byte, ro_hit;
  logic [3:0] rw_idx;
  logic [15:0] rd_word;
  always_comb begin
    rw_hit = 1'b1;
    rw_byte = 1'b0;
    rw_idx = 4'h0;
    unique case (cmd_reg)
      `CMD_OT_WARN: rw_idx = `I_OT_WARN;
      `CMD_UT_WARN: rw_idx = `I_UT_WARN;
      `CMD_UT_FAULT: rw_idx = `I_UT_FAULT;
      `CMD_UT_ACT: begin
        rw_idx = `I_UT_ACT;
        rw_byte = 1'b1;
      end
      `CMD_OV_FAULT: rw_idx = `I_OV_FAULT;
      `CMD_OV_ACT: begin
        rw_idx = `I_OV_ACT;
        rw_byte = 1'b1;
      end
      `CMD_OV_WARN: rw_idx = `I_OV_WARN;
      `CMD_UV_WARN: rw_idx = `I_UV_WARN;
      `CMD_UV_FAULT: rw_idx = `I_UV_FAULT;
      `CMD_UV_ACT: begin
        rw_idx = `I_UV_ACT;
        rw_byte = 1'b1;
      end
      `CMD_PG_ON: rw_idx = `I_PG_ON;
      `CMD_TON_DLY: rw_idx = `I_TON_DLY;
      `CMD_TURN_ON_RISE_TIME: rw_idx = `I_TURN_ON_RISE_TIME;
      `CMD_TOFF_DLY: rw_idx = `I_TOFF_DLY;
      `CMD_TURN_OFF_FALL_TIME: rw_idx = `I_TURN_OFF_FALL_TIME;
      default: rw_hit = 1'b0;
    endcase
  end
  // Status summary; the off state is not reported so idle reads zero
  wire [7:0] stat_byte = {2'b00, fault_reg.vout[7], fault_reg.iout[7],
                          fault_reg.input_st[4], |fault_reg.temp,
                          |cml_reg, 1'b0};
  wire pg_bad = sq_reg == SEQ_ON && !pg_reg;
  wire [15:0] stat_word = {|fault_reg.vout, |fault_reg.iout,
                           |fault_reg.input_st, |fault_reg.mon,
                           pg_bad, 3'b000, stat_byte};
  always_comb begin
    ro_hit = 1'b1;
    rd_word = 16'h0000;
    unique case (cmd_reg)
      `CMD_ST_BYTE: rd_word = {8'h00, stat_byte};
      `CMD_ST_WORD: rd_word = stat_word;
      `CMD_ST_VOUT: rd_word = {8'h00, fault_reg.vout};
      `CMD_ST_IOUT: rd_word = {8'h00, fault_reg.iout};
      `CMD_ST_INPUT: rd_word = {8'h00, fault_reg.input_st};
      `CMD_ST_TEMP: rd_word = {8'h00, fault_reg.temp};
      `CMD_ST_CML: rd_word = {8'h00, cml_reg};
      `CMD_ST_MON: rd_word = {8'h00, fault_reg.mon};
      `CMD_RD_VIN: rd_word = tele_i.vin;
      `CMD_RD_VOUT: rd_word = tele_i.vout;
      `CMD_RD_IOUT: rd_word = tele_i.iout;
      `CMD_RD_TEMP: rd_word = tele_i.temp;
      default: begin
        ro_hit = 1'b0;
        if (rw_hit) rd_word = rw_reg[rw_idx];
      end
    endcase
  end
  // Write commit at stop; a word needs both data bytes
  wire wr_go = bus_stop && st_reg != BUS_IDLE && !rd_reg &&
               bidx_reg >= 3'h3;
  wire wr_ok = rw_hit && (rw_byte || bidx_reg == 3'h4);
  wire [15:0] wr_val = rw_byte ? {8'h00, wlo_reg} : {whi_reg, wlo_reg};
  wire rd_begin = st_reg == BUS_ACK && scl_fall && rd_reg &&
                  rbyte_reg == 2'h0;
  wire set_cmd = (wr_go && !rw_hit && !ro_hit) ||
                 (rd_begin && !rw_hit && !ro_hit);
  wire set_data = wr_go && (ro_hit || (rw_hit && !wr_ok));
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end else begin
      scl_q_reg <= scl_i;
      sda_q_reg <= sda_i;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      st_reg <= BUS_IDLE;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      bidx_reg <= 3'h0;
      rbyte_reg <= 2'h0;
      rd_reg <= 1'b0;
      oe_reg <= 1'b0;
      mack_reg <= 1'b0;
      cmd_reg <= 8'h00;
      wlo_reg <= 8'h00;
      whi_reg <= 8'h00;
      rdw_reg <= 16'h0000;
    end else if (bus_start) begin
      st_reg <= BUS_RX;
      bit_reg <= 4'h0;
      bidx_reg <= 3'h0;
      rbyte_reg <= 2'h0;
      oe_reg <= 1'b0;
    end else if (bus_stop) begin
      st_reg <= BUS_IDLE;
      oe_reg <= 1'b0;
    end else begin
      unique case (st_reg)
        BUS_IDLE: ;
        BUS_RX: begin
          if (scl_rise && bit_reg != 4'h8) begin
            sh_reg <= {sh_reg[6:0], sda_i};
            bit_reg <= bit_reg + 4'h1;
          end else if (byte_done) begin
            // Foreign addresses are left unanswered
            if (bidx_reg == 3'h0 && !addr_ok) begin
              st_reg <= BUS_IDLE;
            end else begin
              st_reg <= BUS_ACK;
              oe_reg <= 1'b1;
            end
            if (bidx_reg == 3'h0) begin
              rd_reg <= sh_reg[0];
              rdw_reg <= rd_word;
            end
            if (bidx_reg == 3'h1) cmd_reg <= sh_reg;
            if (bidx_reg == 3'h2) wlo_reg <= sh_reg;
            if (bidx_reg == 3'h3) whi_reg <= sh_reg;
          end
        end
        BUS_ACK: begin
          if (scl_fall) begin
            bidx_reg <= bidx_inc;
            if (rd_reg) begin
              st_reg <= BUS_TX;
              oe_reg <= ~tx_byte[7];
              sh_reg <= {tx_byte[6:0], 1'b0};
              bit_reg <= 4'h1;
              rbyte_reg <= rbyte_reg == 2'h2 ? rbyte_reg : rbyte_reg + 2'h1;
            end else begin
              st_reg <= BUS_RX;
              oe_reg <= 1'b0;
              bit_reg <= 4'h0;
            end
          end
        end
        BUS_TX: begin
          if (byte_done) begin
            st_reg <= BUS_RACK;
            oe_reg <= 1'b0;
          end else if (scl_fall) begin
            oe_reg <= ~sh_reg[7];
            sh_reg <= {sh_reg[6:0], 1'b0};
            bit_reg <= bit_reg + 4'h1;
          end
        end
        BUS_RACK: begin
          if (scl_rise) begin
            mack_reg <= ~sda_i;
          end else if (scl_fall) begin
            if (mack_reg) begin
              st_reg <= BUS_TX;
              oe_reg <= ~tx_byte[7];
              sh_reg <= {tx_byte[6:0], 1'b0};
              bit_reg <= 4'h1;
              rbyte_reg <= rbyte_reg == 2'h2 ? rbyte_reg : rbyte_reg + 2'h1;
            end else begin
              st_reg <= BUS_IDLE;
            end
          end
        end
      endcase
    end
  end
  // Undervoltage warning default tracks 1.05x the strapped fault limit;
  // mantissa is truncated to 11 bits and may wrap near full scale, exponent is kept
  wire signed [21:0] uvw_prod = $signed(strap_i.uv_fault[10:0]) * `UVW_MUL;
  wire [10:0] uvw_mant = 11'(uvw_prod >>> `UVW_SHIFT);
  assign dflt[`I_OT_WARN] = `DEF_OT_WARN;
  assign dflt[`I_UT_WARN] = `DEF_UT_WARN;
  assign dflt[`I_UT_FAULT] = `DEF_UT_FAULT;
  assign dflt[`I_UT_ACT] = `DEF_ACT;
  assign dflt[`I_OV_FAULT] = `DEF_OV_FAULT;
  assign dflt[`I_OV_ACT] = `DEF_ACT;
  assign dflt[`I_OV_WARN] = `DEF_OV_WARN;
  assign dflt[`I_UV_WARN] = {strap_i.uv_fault[15:11], uvw_mant};
  assign dflt[`I_UV_FAULT] = strap_i.uv_fault;
  assign dflt[`I_UV_ACT] = `DEF_ACT;
  assign dflt[`I_PG_ON] = strap_i.pg_on;
  assign dflt[`I_TON_DLY] = strap_i.ton_dly;
  assign dflt[`I_TURN_ON_RISE_TIME] = strap_i.turn_on_rise_time;
  assign dflt[`I_TOFF_DLY] = strap_i.toff_dly;
  assign dflt[`I_TURN_OFF_FALL_TIME] = strap_i.turn_off_fall_time;
  // Straps are caught by the synchronous reset, never asynchronously
  for (genvar i = 0; i < `NUM_RW; i++) begin : g_rw
    always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) rw_reg[i] <= dflt[i];
      else if (wr_go && wr_ok && rw_idx == 4'(i)) rw_reg[i] <= wr_val;
    end
  end
  // Set wins over a simultaneous clear
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      fault_reg <= '0;
      cml_reg <= 8'h00;
    end else begin
      fault_reg <= fault_i;
      cml_reg[`CML_CMD] <= set_cmd | (cml_reg[`CML_CMD] & ~clear_faults_i);
      cml_reg[`CML_DATA] <= set_data |
                            (cml_reg[`CML_DATA] & ~clear_faults_i);
    end
  end
  // Linear-11 time to whole milliseconds; fractions are dropped
  function automatic logic [15:0] l11_ms(input logic [15:0] w);
    logic [26:0] v;
    logic [4:0] e;
    e = w[15:11];
    v = {16'h0000, w[10:0]};
    if (w[10]) begin
      l11_ms = 16'h0000;
    end else begin
      v = e[4] ? v >> 5'(~e + 5'h1) : v << e;
      l11_ms = |v[26:16] ? 16'hffff : v[15:0];
    end
  endfunction : l11_ms
  wire ms_tick = pre_reg == 32'(CYC_PER_MS - 1);
  logic [15:0] tgt;
  always_comb begin
    tgt = 16'h0000;
    unique case (sq_reg)
      SEQ_TON: tgt = l11_ms(rw_reg[`I_TON_DLY]);
      SEQ_RISE: tgt = l11_ms(rw_reg[`I_TURN_ON_RISE_TIME]);
      SEQ_TOFF: tgt = l11_ms(rw_reg[`I_TOFF_DLY]);
      SEQ_FALL: tgt = l11_ms(rw_reg[`I_TURN_OFF_FALL_TIME]);
      default: tgt = 16'h0000;
    endcase
  end
  wire tmr_done = tmr_reg >= tgt;
  always_comb begin
    sq_next = sq_reg;
    unique case (sq_reg)
      SEQ_OFF: if (enable_i) sq_next = SEQ_TON;
      SEQ_TON: begin
        if (!enable_i) sq_next = SEQ_OFF;
        else if (tmr_done) sq_next = SEQ_RISE;
      end
      SEQ_RISE: begin
        if (!enable_i) sq_next = SEQ_TOFF;
        else if (tmr_done) sq_next = SEQ_ON;
      end
      SEQ_ON: if (!enable_i) sq_next = SEQ_TOFF;
      SEQ_TOFF: if (tmr_done) sq_next = SEQ_FALL;
      SEQ_FALL: if (tmr_done) sq_next = SEQ_OFF;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      sq_reg <= SEQ_OFF;
      pre_reg <= 32'h0;
      tmr_reg <= 16'h0000;
      pg_reg <= 1'b0;
      up_reg <= 1'b0;
      dn_reg <= 1'b0;
      on_reg <= 1'b0;
    end else begin
      sq_reg <= sq_next;
      if (sq_next != sq_reg) begin
        pre_reg <= 32'h0;
        tmr_reg <= 16'h0000;
      end else begin
        pre_reg <= ms_tick ? 32'h0 : pre_reg + 32'h1;
        if (ms_tick && tmr_reg != 16'hffff) tmr_reg <= tmr_reg + 16'h1;
      end
      pg_reg <= sq_next == SEQ_ON &&
                tele_i.vout >= rw_reg[`I_PG_ON];
      up_reg <= sq_next == SEQ_RISE;
      dn_reg <= sq_next == SEQ_FALL;
      on_reg <= sq_next == SEQ_ON;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = oe_reg;
  assign pgood_o = pg_reg;
  assign ramp_up_o = up_reg;
  assign ramp_down_o = dn_reg;
  assign out_on_o = on_reg;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  property p_ot_def;
    $rose(nrst_i) |-> rw_reg[`I_OT_WARN] == 16'heb48;
  endproperty
  a_ot_def: assert property (p_ot_def) else $error("ot warn default");
  property p_ut_def;
    $rose(nrst_i) |-> rw_reg[`I_UT_WARN] == 16'hdc40;
  endproperty
  a_ut_def: assert property (p_ut_def) else $error("ut warn default");
  property p_utf_def;
    $rose(nrst_i) |-> rw_reg[`I_UT_FAULT] == 16'he580;
  endproperty
  a_utf_def: assert property (p_utf_def) else $error("ut fault dflt");
  property p_act_def;
    $rose(nrst_i) |-> rw_reg[`I_UT_ACT] == 16'h0080 &&
      rw_reg[`I_OV_ACT] == 16'h0080 && rw_reg[`I_UV_ACT] == 16'h0080;
  endproperty
  a_act_def: assert property (p_act_def) else $error("action dflt");
  property p_ov_def;
    $rose(nrst_i) |-> rw_reg[`I_OV_FAULT] == 16'hd380 &&
      rw_reg[`I_OV_WARN] == 16'hd353;
  endproperty
  a_ov_def: assert property (p_ov_def) else $error("ov defaults");
  property p_uv_def;
    $rose(nrst_i) |-> rw_reg[`I_UV_FAULT] == $past(strap_i.uv_fault);
  endproperty
  a_uv_def: assert property (p_uv_def) else $error("uv strap dflt");
  sequence s_ton_wait;
    sq_reg == SEQ_TON && !tmr_done && enable_i;
  endsequence
  property p_ton;
    s_ton_wait |=> !ramp_up_o;
  endproperty
  a_ton: assert property (p_ton) else $error("rise before delay");
  property p_toff;
    sq_reg == SEQ_ON && !enable_i |=> sq_reg == SEQ_TOFF ##1 !on_reg;
  endproperty
  a_toff: assert property (p_toff) else $error("off not delayed");
  property p_stat0;
    fault_reg == '0 && cml_reg == 8'h00 |->
      stat_word == {4'h0, sq_reg == SEQ_ON && !pgood_o, 11'h000};
  endproperty
  a_stat0: assert property (p_stat0) else $error("status not zero");
  sequence s_ro_write;
    wr_go && ro_hit;
  endsequence
  property p_ro_wr;
    s_ro_write |=> cml_reg[`CML_DATA] && $stable(rw_reg[rw_idx]);
  endproperty
  a_ro_wr: assert property (p_ro_wr) else $error("ro write unflagged");
endmodule : pmb_limit_bank

// file: tb/pmb_host_model.sv
`timescale 1ns/10ps
module pmb_host_model (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask : tick

  // Serves as repeated start too: SDA falls while SCL is high
  task automatic start_cond();
    tick(1);
    sda_oe_o = 1'b0;
    tick(3);
    scl_o = 1'b1;
    tick(4);
    sda_oe_o = 1'b1;
    tick(4);
    scl_o = 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    tick(1);
    sda_oe_o = 1'b1;
    tick(3);
    scl_o = 1'b1;
    tick(4);
    sda_oe_o = 1'b0;
    tick(4);
  endtask : stop_cond

  // Data moves only in the low phase, so no false start or stop
  task automatic bit_cell(input logic b, output logic s);
    tick(1);
    sda_oe_o = ~b;
    tick(3);
    scl_o = 1'b1;
    tick(2);
    s = sda_i;
    tick(2);
    scl_o = 1'b0;
  endtask : bit_cell

  // Send ff to read; rel 1 leaves SDA free for the ack cell
  task automatic xfer_byte(input logic [7:0] d, input logic rel,
                           output logic [7:0] q, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cell(d[i], s);
      q[i] = s;
    end
    bit_cell(rel, s);
    ack = ~s;
  endtask : xfer_byte
endmodule : pmb_host_model

// file: tb/pmb_limit_bank_tb.sv
`timescale 1ns/10ps
module pmb_limit_bank_tb;
  import pmb_pkg::*;
  localparam logic [6:0] ADDR = 7'h40;
  localparam logic [7:0] DEF_CMD [8] = '{8'h51, 8'h52, 8'h53, 8'h54,
    8'h55, 8'h56, 8'h57, 8'h5a};
  localparam logic [15:0] DEF_VAL [8] = '{16'heb48, 16'hdc40, 16'he580,
    16'h0080, 16'hd380, 16'h0080, 16'hd353, 16'h0080};
  localparam logic [7:0] ST_CMD [8] = '{8'h78, 8'h79, 8'h7a, 8'h7b, 8'h7c,
    8'h7d, 8'h7e, 8'h80};
  localparam logic [7:0] RW_CMD [15] = '{8'h51, 8'h52, 8'h53, 8'h54,
    8'h55, 8'h56, 8'h57, 8'h58, 8'h59, 8'h5a, 8'h5e, 8'h60, 8'h61, 8'h64,
    8'h65};
  logic clk_sys_i = 1'b0;
  logic nrst_i, enable_i, clear_faults_i;
  pmb_strap_t strap_i;
  pmb_fault_t fault_i;
  pmb_tele_t tele_i;
  logic scl, host_oe, sda_o, sda_oe_o, sda_w;
  logic pgood_o, ramp_up_o, ramp_down_o, out_on_o;
  int miscompares = 0;
  int comparisons = 0;

  always #25 clk_sys_i = ~clk_sys_i;
  // SDA has a pull-up: it is high unless someone pulls it low
  assign sda_w = ~host_oe & (~sda_oe_o | sda_o);

  pmb_limit_bank #(.DEV_ADDR(ADDR), .CYC_PER_MS(4)) u_pmb_limit_bank (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .enable_i(enable_i),
    .clear_faults_i(clear_faults_i), .strap_i(strap_i), .fault_i(fault_i),
    .tele_i(tele_i), .pgood_o(pgood_o), .ramp_up_o(ramp_up_o),
    .ramp_down_o(ramp_down_o), .out_on_o(out_on_o));
  pmb_host_model u_pmb_host_model (.clk_i(clk_sys_i), .sda_i(sda_w),
    .scl_o(scl), .sda_oe_o(host_oe));

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_span(input int n, input int lo, input int hi);
    comparisons++;
    if (n < lo || n > hi) begin
      miscompares++;
      $display("CHECK FAILED at %0t: phase %0d clocks", $time, n);
    end
  endtask : check_span

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : tick

  task automatic wr(input logic [7:0] cmd, input logic [15:0] d,
                    input int nb);
    logic [7:0] q;
    logic a0, a1, a2, a3;
    a3 = 1'b1;
    u_pmb_host_model.start_cond();
    u_pmb_host_model.xfer_byte({ADDR, 1'b0}, 1'b1, q, a0);
    u_pmb_host_model.xfer_byte(cmd, 1'b1, q, a1);
    u_pmb_host_model.xfer_byte(d[7:0], 1'b1, q, a2);
    if (nb == 2)
      u_pmb_host_model.xfer_byte(d[15:8], 1'b1, q, a3);
    u_pmb_host_model.stop_cond();
    check_word({12'h0, a0, a1, a2, a3}, 16'h000f);
  endtask : wr

  // Word read, low byte first, host NACKs the high byte
  task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
    logic [7:0] lo, hi, q;
    logic a0, a1, a2, a3;
    u_pmb_host_model.start_cond();
    u_pmb_host_model.xfer_byte({ADDR, 1'b0}, 1'b1, q, a0);
    u_pmb_host_model.xfer_byte(cmd, 1'b1, q, a1);
    u_pmb_host_model.start_cond();
    u_pmb_host_model.xfer_byte({ADDR, 1'b1}, 1'b1, q, a2);
    u_pmb_host_model.xfer_byte(8'hff, 1'b0, lo, a3);
    u_pmb_host_model.xfer_byte(8'hff, 1'b1, hi, a3);
    u_pmb_host_model.stop_cond();
    check_word({13'h0, a0, a1, a2}, 16'h0007);
    check_word({hi, lo}, exp);
  endtask : rd

  task automatic wait_sig(input int w, input logic lvl, output int n);
    logic s;
    n = 0;
    while (n < 200) begin
      case (w)
        0: s = ramp_up_o;
        1: s = ramp_down_o;
        default: s = out_on_o;
      endcase
      if (s === lvl)
        break;
      tick(1);
      n++;
    end
  endtask : wait_sig

  // Exponent kept, mantissa scaled by 1075/1024 (about 1.05)
  function automatic logic [15:0] uvw(input logic [15:0] f);
    logic [21:0] m;
    m = 22'(f[10:0]) * 22'd1075;
    return {f[15:11], m[20:10]};
  endfunction : uvw

  initial begin
    logic [15:0] v;
    logic isb;
    int n;
    nrst_i = 1'b0;
    enable_i = 1'b0;
    clear_faults_i = 1'b0;
    strap_i = '{uv_fault: 16'hd100, pg_on: 16'h0100, ton_dly: 16'h0001,
      turn_on_rise_time: 16'h0004, toff_dly: 16'h0003, turn_off_fall_time: 16'h0006};
    fault_i = '0;
    tele_i = '{vin: 16'h1a2b, vout: 16'h0200, iout: 16'h3c4d,
      temp: 16'h5e6f};
    tick(8);
    nrst_i = 1'b1;
    tick(2);
    for (int i = 0; i < 8; i++)
      rd(DEF_CMD[i], DEF_VAL[i]);
    rd(8'h58, uvw(16'hd100));
    rd(8'h59, 16'hd100);
    rd(8'h5e, 16'h0100);
    rd(8'h60, 16'h0001);
    rd(8'h61, 16'h0004);
    rd(8'h64, 16'h0003);
    rd(8'h65, 16'h0006);
    for (int i = 0; i < 8; i++)
      rd(ST_CMD[i], 16'h0000);
    $display("test reset values done");
    // Phase windows allow a few clocks of slack; the millisecond tick restarts at each phase change
    enable_i = 1'b1;
    wait_sig(0, 1'b1, n);
    check_span(n, 2, 8);
    wait_sig(2, 1'b1, n);
    check_span(n, 14, 20);
    check_word({15'h0, ramp_up_o}, 16'h0000);
    tick(3);
    check_word({15'h0, pgood_o}, 16'h0001);
    tele_i.vout = 16'h00ff;
    tick(3);
    check_word({15'h0, pgood_o}, 16'h0000);
    rd(8'h79, 16'h0800);
    tele_i.vout = 16'h0200;
    enable_i = 1'b0;
    wait_sig(1, 1'b1, n);
    check_span(n, 10, 16);
    wait_sig(1, 1'b0, n);
    check_span(n, 22, 28);
    check_word({14'h0, out_on_o, ramp_up_o}, 16'h0000);
    $display("test sequencer done");
    rd(8'h88, 16'h1a2b);
    rd(8'h8b, 16'h0200);
    rd(8'h8c, 16'h3c4d);
    rd(8'h8d, 16'h5e6f);
    fault_i = '{vout: 8'h80, iout: 8'h80, input_st: 8'h10, temp: 8'h01,
      mon: 8'h02};
    tick(4);
    rd(8'h7a, 16'h0080);
    rd(8'h7b, 16'h0080);
    rd(8'h7c, 16'h0010);
    rd(8'h7d, 16'h0001);
    rd(8'h80, 16'h0002);
    rd(8'h78, 16'h003c);
    rd(8'h79, 16'hf03c);
    fault_i = '0;
    $display("test telemetry done");
    for (int i = 0; i < 15; i++) begin
      isb = RW_CMD[i] inside {8'h54, 8'h56, 8'h5a};
      v = {8'h10 + 8'(i), 8'hc3 - 8'(i)};
      wr(RW_CMD[i], v, isb ? 1 : 2);
      rd(RW_CMD[i], isb ? {8'h00, v[7:0]} : v);
    end
    rd(8'h7e, 16'h0000);
    $display("test write readback done");
    wr(8'h88, 16'h1111, 2);
    rd(8'h88, 16'h1a2b);
    rd(8'h7e, 16'h0040);
    wr(8'h70, 16'h2222, 2);
    rd(8'h7e, 16'h00c0);
    rd(8'h78, 16'h0002);
    clear_faults_i = 1'b1;
    tick(2);
    clear_faults_i = 1'b0;
    tick(2);
    rd(8'h7e, 16'h0000);
    wr(8'h51, 16'h00aa, 1);
    rd(8'h51, 16'h10c3);
    rd(8'h7e, 16'h0040);
    $display("test refusals done");
    tally_and_finish();
  end

  initial begin
    repeat (60000) @(posedge clk_sys_i);
    miscompares++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    tally_and_finish();
  end
endmodule : pmb_limit_bank_tb
